// >>> verilog/adcsg_pkg.sv
package adcsg_pkg;

	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] ADCSG_OFS_SLOT_DISABLE = 8'h00;
	localparam logic [7:0] ADCSG_OFS_SCAN_STATUS = 8'h04;
	localparam logic [7:0] ADCSG_OFS_SCAN_CONTROL = 8'h08;

	localparam int ADCSG_SLOTS = 8;
	localparam int ADCSG_HALF = 4;

	// ----------------------------------------
	// Status register fields
	// ----------------------------------------
	localparam int ADCSG_ST_ACTIVE_A = 15;
	localparam int ADCSG_ST_ACTIVE_B = 14;
	localparam int ADCSG_ST_DONE_B = 12;
	localparam int ADCSG_ST_DONE_A = 11;
	localparam int ADCSG_ST_SIGN = 10;
	localparam int ADCSG_ST_BELOW = 9;
	localparam int ADCSG_ST_ABOVE = 8;
	localparam int ADCSG_ST_READY_LSB = 0;

	// ----------------------------------------
	// Control register fields
	// ----------------------------------------
	localparam int ADCSG_CT_PARALLEL = 0;
	localparam int ADCSG_CT_SIMULTANEOUS_PARALLEL = 1;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] ADCSG_RST_SLOT_DISABLE = 8'h00;
	localparam logic [1:0] ADCSG_RST_CONTROL = 2'h0;
	localparam logic [7:0] ADCSG_RST_READY = 8'h00;

	typedef enum logic [1:0] {
		ADCSG_SEQUENTIAL,
		ADCSG_PAR_SIMULTANEOUS_PARALLEL,
		ADCSG_PAR_INDEPENDENT
	} adcsg_mode_t;

endpackage : adcsg_pkg

// >>> verilog/adcsg_slot_mask.sv
`timescale 1ns/10ps
module adcsg_slot_mask
	import adcsg_pkg::*;
(
	input wire logic [ADCSG_SLOTS-1:0] slot_disable_bit,
	input wire adcsg_mode_t mode,
	output logic [ADCSG_SLOTS-1:0] slot_enable
);

	// ----------------------------------------
	// Truncation helper
	// ----------------------------------------
	// Bit i stays enabled only if no disable bit at or below i
	function automatic logic [ADCSG_HALF-1:0] adcsg_truncate(input logic [ADCSG_HALF-1:0] ds);
		logic [ADCSG_HALF-1:0] en;
		logic stop;
		en = '0;
		stop = 1'b0;
		for (int i = 0; i < ADCSG_HALF; i++)
		begin
			stop = stop | ds[i];
			en[i] = ~stop;
		end
		return en;
	endfunction : adcsg_truncate

	logic [ADCSG_HALF-1:0] pair_en;
	logic [ADCSG_HALF-1:0] lo_en;
	logic [ADCSG_HALF-1:0] hi_en;

	always_comb
	begin
		pair_en = adcsg_truncate(slot_disable_bit[3:0] | slot_disable_bit[7:4]);
		lo_en = adcsg_truncate(slot_disable_bit[3:0]);
		hi_en = adcsg_truncate(slot_disable_bit[7:4]);
		unique case (mode)
			ADCSG_SEQUENTIAL:
			begin
				// One list of eight slots, cut at the first disable
				slot_enable = {hi_en & {ADCSG_HALF{lo_en[3]}}, lo_en};
			end
			ADCSG_PAR_SIMULTANEOUS_PARALLEL:
			begin
				// Both converters step together, so one cut stops both
				slot_enable = {pair_en, pair_en};
			end
			default:
			begin
				slot_enable = {hi_en, lo_en};
			end
		endcase
	end

endmodule : adcsg_slot_mask

// >>> verilog/adcsg_scan_status.sv
`timescale 1ns/10ps
// Functional notes
// - Disable bit skips its slot and later
// - Skipped slots depend on scan mode
// - Sequential cut at slot; simultaneous cuts both halves
// - Ready flag clears on result read
// - Limit flags clear once limit bits cleared
// - Sign change flag clears once bits cleared
// - Done flags write-one-clear, never software set
// - All flags except active bits sticky
// - Active A covers sequential, simultaneous, converter A
// - Active B only for independent parallel B
// - Active converter ignores sync and start
// - Done B from converter B independent parallel
// - Done A on sequential, simultaneous or converter A completion
// - Done flag set on each scan end while active
// - Sign change flag set per conversion
// - Below limit flag set when enabled
// - Above limit flag set when enabled
module adcsg_scan_status
	import adcsg_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic trigger_a,
	input wire logic trigger_b,
	input wire logic scan_end_a,
	input wire logic scan_end_b,
	output logic launch_a,
	output logic launch_b,
	output logic [ADCSG_SLOTS-1:0] slot_enable,
	input wire logic [ADCSG_SLOTS-1:0] sample_stored,
	input wire logic [ADCSG_SLOTS-1:0] result_read,
	input wire logic below_limit_enabled,
	input wire logic above_limit_enabled,
	input wire logic below_limit_event,
	input wire logic above_limit_event,
	input wire logic sign_change_event,
	input wire logic [ADCSG_SLOTS-1:0] below_limit_bits,
	input wire logic [ADCSG_SLOTS-1:0] above_limit_bits,
	input wire logic [ADCSG_SLOTS-1:0] sign_change_bits
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [ADCSG_SLOTS-1:0] slot_disable_bit;
	logic [ADCSG_SLOTS-1:0] next_slot_disable_bit;
	logic parallel_scan;
	logic next_parallel_scan;
	logic simultaneous_parallel;
	logic next_simultaneous_parallel;
	logic scan_active_a;
	logic next_scan_active_a;
	logic scan_active_b;
	logic next_scan_active_b;
	logic scan_done_a;
	logic next_scan_done_a;
	logic scan_done_b;
	logic next_scan_done_b;
	logic sign_change_flag;
	logic next_sign_change_flag;
	logic below_limit_flag;
	logic next_below_limit_flag;
	logic above_limit_flag;
	logic next_above_limit_flag;
	logic [ADCSG_SLOTS-1:0] sample_ready;
	logic [ADCSG_SLOTS-1:0] next_sample_ready;
	logic next_launch_a;
	logic next_launch_b;
	logic [31:0] next_prdata;

	adcsg_mode_t mode;
	// Set once the pending read has its data loaded
	logic rd_loaded;
	logic next_rd_loaded;
	logic rd_capture;
	logic wr_access;
	logic mapped;
	logic wr_status;
	logic [15:0] status_word;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	function automatic logic adcsg_hit(input logic [7:0] addr, input logic [7:0] ofs);
		return addr == ofs;
	endfunction : adcsg_hit

	// Simultaneous bit counts only with parallel set
	always_comb
	begin
		if (!parallel_scan)
		begin
			mode = ADCSG_SEQUENTIAL;
		end
		else if (simultaneous_parallel)
		begin
			mode = ADCSG_PAR_SIMULTANEOUS_PARALLEL;
		end
		else
		begin
			mode = ADCSG_PAR_INDEPENDENT;
		end
	end

	assign mapped = adcsg_hit(paddr, ADCSG_OFS_SLOT_DISABLE)
		| adcsg_hit(paddr, ADCSG_OFS_SCAN_STATUS)
		| adcsg_hit(paddr, ADCSG_OFS_SCAN_CONTROL);
	// Normally loads in setup; a frozen setup edge costs one wait state
	assign rd_capture = psel & ~pwrite & ~rd_loaded;
	// Writes land on the single access edge that pready completes
	assign wr_access = psel & penable & pwrite & clk_en & mapped;
	assign wr_status = wr_access & adcsg_hit(paddr, ADCSG_OFS_SCAN_STATUS);
	// Stall the bus while frozen, and until read data has been loaded
	assign pready = clk_en & (pwrite | rd_loaded);
	// Unmapped accesses complete normally but flag an error
	assign pslverr = psel & penable & ~mapped;

	assign status_word = {scan_active_a, scan_active_b, 1'b0, scan_done_b, scan_done_a,
		sign_change_flag, below_limit_flag, above_limit_flag, sample_ready};

	adcsg_slot_mask u_slot_mask (
		.slot_disable_bit(slot_disable_bit),
		.mode(mode),
		.slot_enable(slot_enable)
	);

	// ----------------------------------------
	// Registers and flags, next values
	// ----------------------------------------
	always_comb
	begin
		next_slot_disable_bit = slot_disable_bit;
		next_parallel_scan = parallel_scan;
		next_simultaneous_parallel = simultaneous_parallel;
		next_prdata = prdata;
		next_rd_loaded = rd_loaded;
		if (wr_access && adcsg_hit(paddr, ADCSG_OFS_SLOT_DISABLE))
		begin
			next_slot_disable_bit = pwdata[ADCSG_SLOTS-1:0];
		end
		if (wr_access && adcsg_hit(paddr, ADCSG_OFS_SCAN_CONTROL))
		begin
			next_parallel_scan = pwdata[ADCSG_CT_PARALLEL];
			next_simultaneous_parallel = pwdata[ADCSG_CT_SIMULTANEOUS_PARALLEL];
		end
		// A completed read frees the capture for the next one
		if (psel && penable && rd_loaded)
		begin
			next_rd_loaded = 1'b0;
		end
		// Stale data would be returned if the capture waited for access
		if (rd_capture)
		begin
			next_rd_loaded = 1'b1;
			if (adcsg_hit(paddr, ADCSG_OFS_SLOT_DISABLE))
			begin
				next_prdata = {24'h000000, slot_disable_bit};
			end
			else if (adcsg_hit(paddr, ADCSG_OFS_SCAN_STATUS))
			begin
				next_prdata = {16'h0000, status_word};
			end
			else if (adcsg_hit(paddr, ADCSG_OFS_SCAN_CONTROL))
			begin
				next_prdata = {30'h0000000, simultaneous_parallel, parallel_scan};
			end
			else
			begin
				next_prdata = 32'h00000000;
			end
		end
	end

	// ----------------------------------------
	// Scan sequencing, next values
	// ----------------------------------------
	always_comb
	begin
		next_launch_a = 1'b0;
		next_launch_b = 1'b0;
		next_scan_active_a = scan_active_a;
		next_scan_active_b = scan_active_b;
		next_scan_done_a = scan_done_a;
		next_scan_done_b = scan_done_b;
		// End first, so a new trigger needs the next cycle
		if (scan_active_a && scan_end_a)
		begin
			next_scan_active_a = 1'b0;
		end
		else if (!scan_active_a && trigger_a)
		begin
			next_scan_active_a = 1'b1;
			next_launch_a = 1'b1;
		end
		if (mode == ADCSG_PAR_INDEPENDENT)
		begin
			if (scan_active_b && scan_end_b)
			begin
				next_scan_active_b = 1'b0;
			end
			else if (!scan_active_b && trigger_b)
			begin
				next_scan_active_b = 1'b1;
				next_launch_b = 1'b1;
			end
		end
		else
		begin
			// Converter B is unused outside independent parallel
			next_scan_active_b = 1'b0;
		end
		// Only the done bits react to status writes
		if (wr_status && pwdata[ADCSG_ST_DONE_A])
		begin
			next_scan_done_a = 1'b0;
		end
		if (wr_status && pwdata[ADCSG_ST_DONE_B])
		begin
			next_scan_done_b = 1'b0;
		end
		// Only an end pulse while active sets it; later pulses need a new launch
		if (scan_active_a && scan_end_a)
		begin
			next_scan_done_a = 1'b1;
		end
		if (mode == ADCSG_PAR_INDEPENDENT && scan_active_b && scan_end_b)
		begin
			next_scan_done_b = 1'b1;
		end
	end

	// ----------------------------------------
	// Summary flags, next values
	// ----------------------------------------
	always_comb
	begin
		// Each limit flag only rises while its own limit register is enabled
		// Hold while any detail bit stays set; all cleared drops it
		next_sample_ready = (sample_ready & ~result_read) | sample_stored;
		next_sign_change_flag = sign_change_event
			| (sign_change_flag & (|sign_change_bits));
		next_below_limit_flag = (below_limit_event & below_limit_enabled)
			| (below_limit_flag & (|below_limit_bits));
		next_above_limit_flag = (above_limit_event & above_limit_enabled)
			| (above_limit_flag & (|above_limit_bits));
	end

	// ----------------------------------------
	// Flip-flops
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			slot_disable_bit <= ADCSG_RST_SLOT_DISABLE;
			parallel_scan <= ADCSG_RST_CONTROL[ADCSG_CT_PARALLEL];
			simultaneous_parallel <= ADCSG_RST_CONTROL[ADCSG_CT_SIMULTANEOUS_PARALLEL];
			scan_active_a <= 1'b0;
			scan_active_b <= 1'b0;
			scan_done_a <= 1'b0;
			scan_done_b <= 1'b0;
			sign_change_flag <= 1'b0;
			below_limit_flag <= 1'b0;
			above_limit_flag <= 1'b0;
			sample_ready <= ADCSG_RST_READY;
			launch_a <= 1'b0;
			launch_b <= 1'b0;
			prdata <= 32'h00000000;
			rd_loaded <= 1'b0;
		end
		// Frozen cycles keep every flop, bus state included
		else if (clk_en)
		begin
			slot_disable_bit <= next_slot_disable_bit;
			parallel_scan <= next_parallel_scan;
			simultaneous_parallel <= next_simultaneous_parallel;
			scan_active_a <= next_scan_active_a;
			scan_active_b <= next_scan_active_b;
			scan_done_a <= next_scan_done_a;
			scan_done_b <= next_scan_done_b;
			sign_change_flag <= next_sign_change_flag;
			below_limit_flag <= next_below_limit_flag;
			above_limit_flag <= next_above_limit_flag;
			sample_ready <= next_sample_ready;
			launch_a <= next_launch_a;
			launch_b <= next_launch_b;
			prdata <= next_prdata;
			rd_loaded <= next_rd_loaded;
		end
	end

endmodule : adcsg_scan_status

// >>> bench/adcsg_seq_model.sv
`timescale 1ns/10ps
module adcsg_seq_model
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic launch,
	input wire logic [7:0] len,
	output logic scan_end
);
	// ---------------------------
	// Sequencer: end pulse len cycles after launch
	// ---------------------------
	logic [7:0] cnt;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt <= 8'h00;
			scan_end <= 1'b0;
		end
		else
		begin
			scan_end <= (cnt == 8'h01);
			if (launch)
				cnt <= len;
			else if (cnt != 8'h00)
				cnt <= cnt - 8'h01;
		end
	end
endmodule : adcsg_seq_model

// >>> bench/adcsg_scan_status_sva.sv
`timescale 1ns/10ps
module adcsg_chk
	import adcsg_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic pready,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic trigger_a,
	input wire logic trigger_b,
	input wire logic launch_a,
	input wire logic launch_b,
	input wire logic [ADCSG_SLOTS-1:0] slot_enable
);
	// ---------------------------
	// Shadow of disable and control
	// ---------------------------
	logic [7:0] dis, next_dis;
	logic [1:0] ctl, next_ctl;
	function automatic logic [7:0] low(input logic [7:0] d);
		return (d & (~d + 8'h01)) - 8'h01;
	endfunction : low
	function automatic logic [3:0] low4(input logic [3:0] d);
		return 4'(low({4'h1, d}));
	endfunction : low4
	always_comb
	begin
		next_dis = dis;
		next_ctl = ctl;
		if (psel && penable && pwrite && pready && paddr == ADCSG_OFS_SLOT_DISABLE)
			next_dis = pwdata[7:0];
		if (psel && penable && pwrite && pready && paddr == ADCSG_OFS_SCAN_CONTROL)
			next_ctl = pwdata[1:0];
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			dis <= 8'h00;
			ctl <= 2'h0;
		end
		else
		begin
			dis <= next_dis;
			ctl <= next_ctl;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_la_cause; launch_a |-> $past(trigger_a); endproperty
	a_la_cause: assert property (p_la_cause) else $error("launch_a uncaused");
	property p_la_once; launch_a |=> !launch_a; endproperty
	a_la_once: assert property (p_la_once) else $error("launch_a twice");
	property p_lb_once; launch_b |=> !launch_b; endproperty
	a_lb_once: assert property (p_lb_once) else $error("launch_b twice");
	property p_lb_cause; launch_b |-> $past(trigger_b) && ctl == 2'h1; endproperty
	a_lb_cause: assert property (p_lb_cause) else $error("launch_b bad");
	property p_off; (slot_enable & dis) == 8'h00; endproperty
	a_off: assert property (p_off) else $error("disabled slot on");
	property p_seq; ctl == 2'h0 |-> slot_enable == low(dis); endproperty
	a_seq: assert property (p_seq) else $error("sequential cut");
	property p_sim; ctl == 2'h3 |-> slot_enable == {2{low4(dis[3:0] | dis[7:4])}}; endproperty
	a_sim: assert property (p_sim) else $error("simultaneous cut");
	property p_ind; ctl == 2'h1 |-> slot_enable == {low4(dis[7:4]), low4(dis[3:0])}; endproperty
	a_ind: assert property (p_ind) else $error("independent cut");
endmodule : adcsg_chk
bind adcsg_scan_status adcsg_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .pready,
	.paddr, .pwdata, .trigger_a, .trigger_b, .launch_a, .launch_b, .slot_enable);

// >>> bench/adcsg_scan_status_tb.sv
`timescale 1ns/10ps
module adcsg_scan_status_tb
	import adcsg_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, clk_en, slv_err;
	logic trigger_a, trigger_b, scan_end_a, scan_end_b, launch_a, launch_b;
	logic below_limit_enabled, above_limit_enabled;
	logic below_limit_event, above_limit_event, sign_change_event;
	logic [7:0] paddr, slot_enable, sample_stored, result_read;
	logic [7:0] below_limit_bits, above_limit_bits, sign_change_bits;
	logic [31:0] pwdata, prdata, q;
	logic [23:0] cut [6] = '{24'h00201F, 24'h000100, 24'h030211, 24'h032011,
		24'h0104F3, 24'h01807F};
	int n_errors = 0, comparisons = 0, n_la = 0, n_lb = 0, k;
	adcsg_scan_status dut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .trigger_a, .trigger_b, .scan_end_a,
		.scan_end_b, .launch_a, .launch_b, .slot_enable, .sample_stored, .result_read,
		.below_limit_enabled, .above_limit_enabled, .below_limit_event, .above_limit_event,
		.sign_change_event, .below_limit_bits, .above_limit_bits, .sign_change_bits);
	adcsg_seq_model seq_a (.pclk, .presetn, .launch(launch_a), .len(8'h14), .scan_end(scan_end_a));
	adcsg_seq_model seq_b (.pclk, .presetn, .launch(launch_b), .len(8'h06), .scan_end(scan_end_b));
	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk)
	begin
		n_la <= n_la + int'(launch_a === 1'b1);
		n_lb <= n_lb + int'(launch_b === 1'b1);
	end
	// ---------------------------
	// Bus and stimulus tasks
	// ---------------------------
	task close_out;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : close_out
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 50; i++)
		begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (i == 50)
		begin
			n_errors++;
			close_out();
		end
		q = prdata;
		slv_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(q, e);
	endtask : rd
	task pulse(input logic [4:0] ev, input logic [7:0] s, input logic [7:0] r);
		@(posedge pclk);
		{trigger_b, trigger_a, above_limit_event, below_limit_event, sign_change_event} <= ev;
		sample_stored <= s;
		result_read <= r;
		@(posedge pclk);
		{trigger_b, trigger_a, above_limit_event, below_limit_event, sign_change_event} <= 5'h00;
		sample_stored <= 8'h00;
		result_read <= 8'h00;
	endtask : pulse
	task lvl(input logic [23:0] v);
		@(posedge pclk);
		{above_limit_bits, below_limit_bits, sign_change_bits} <= v;
		@(posedge pclk);
	endtask : lvl
	task wait_bit(input int b, input logic v);
		int i;
		for (i = 0; i < 40; i++)
		begin
			apb(1'b0, ADCSG_OFS_SCAN_STATUS, 32'h0);
			if (q[b] === v) break;
		end
		if (i == 40)
		begin
			n_errors++;
			close_out();
		end
	endtask : wait_bit
	initial
	begin
		{psel, penable, pwrite, trigger_a, trigger_b, below_limit_enabled} = 6'h00;
		{below_limit_event, above_limit_event, sign_change_event, presetn} = 4'h0;
		{paddr, sample_stored, result_read} = 24'h000000;
		{above_limit_bits, below_limit_bits, sign_change_bits} = 24'h000000;
		pwdata = 32'h0;
		clk_en = 1'b1;
		above_limit_enabled = 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(ADCSG_OFS_SCAN_STATUS, 32'h0);
		rd(ADCSG_OFS_SCAN_CONTROL, 32'h0);
		chk({31'h0, slv_err}, 32'h0);
		rd(8'h0C, 32'h0);
		chk({31'h0, slv_err}, 32'h1);
		chk({24'h0, slot_enable}, 32'hFF);
		for (k = 0; k < 6; k++)
		begin
			apb(1'b1, ADCSG_OFS_SCAN_CONTROL, {24'h0, cut[k][23:16]});
			apb(1'b1, ADCSG_OFS_SLOT_DISABLE, {24'h0, cut[k][15:8]});
			#1 chk({24'h0, slot_enable}, {24'h0, cut[k][7:0]});
			rd(ADCSG_OFS_SLOT_DISABLE, {24'h0, cut[k][15:8]});
		end
		apb(1'b1, ADCSG_OFS_SLOT_DISABLE, 32'h0);
		apb(1'b1, ADCSG_OFS_SCAN_CONTROL, 32'h0);
		pulse(5'h08, 8'h00, 8'h00);
		pulse(5'h08, 8'h00, 8'h00);
		rd(ADCSG_OFS_SCAN_STATUS, 32'h8000);
		wait_bit(11, 1'b1);
		rd(ADCSG_OFS_SCAN_STATUS, 32'h0800);
		chk(n_la, 1);
		apb(1'b1, ADCSG_OFS_SCAN_STATUS, 32'h0800);
		rd(ADCSG_OFS_SCAN_STATUS, 32'h0);
		pulse(5'h08, 8'h00, 8'h00);
		wait_bit(15, 1'b0);
		rd(ADCSG_OFS_SCAN_STATUS, 32'h0800);
		apb(1'b1, ADCSG_OFS_SCAN_STATUS, 32'hF7FF);
		rd(ADCSG_OFS_SCAN_STATUS, 32'h0800);
		apb(1'b1, ADCSG_OFS_SCAN_STATUS, 32'h0800);
		rd(ADCSG_OFS_SCAN_STATUS, 32'h0);
		apb(1'b1, ADCSG_OFS_SCAN_CONTROL, 32'h1);
		pulse(5'h10, 8'h00, 8'h00);
		rd(ADCSG_OFS_SCAN_STATUS, 32'h4000);
		wait_bit(12, 1'b1);
		rd(ADCSG_OFS_SCAN_STATUS, 32'h1000);
		pulse(5'h10, 8'h00, 8'h00);
		repeat (5) @(posedge pclk);
		apb(1'b1, ADCSG_OFS_SCAN_STATUS, 32'h1000);
		rd(ADCSG_OFS_SCAN_STATUS, 32'h1000);
		pulse(5'h08, 8'h00, 8'h00);
		wait_bit(11, 1'b1);
		rd(ADCSG_OFS_SCAN_STATUS, 32'h1800);
		apb(1'b1, ADCSG_OFS_SCAN_STATUS, 32'h1800);
		apb(1'b1, ADCSG_OFS_SCAN_CONTROL, 32'h3);
		pulse(5'h10, 8'h00, 8'h00);
		pulse(5'h08, 8'h00, 8'h00);
		rd(ADCSG_OFS_SCAN_STATUS, 32'h8000);
		wait_bit(11, 1'b1);
		rd(ADCSG_OFS_SCAN_STATUS, 32'h0800);
		chk(n_lb, 2);
		apb(1'b1, ADCSG_OFS_SCAN_STATUS, 32'h0800);
		pulse(5'h00, 8'h09, 8'h00);
		pulse(5'h00, 8'h00, 8'h01);
		rd(ADCSG_OFS_SCAN_STATUS, 32'h0008);
		lvl(24'h010204);
		pulse(5'h07, 8'h00, 8'h00);
		rd(ADCSG_OFS_SCAN_STATUS, 32'h0408);
		below_limit_enabled <= 1'b1;
		pulse(5'h02, 8'h00, 8'h00);
		rd(ADCSG_OFS_SCAN_STATUS, 32'h0608);
		above_limit_enabled <= 1'b1;
		pulse(5'h04, 8'h00, 8'h00);
		rd(ADCSG_OFS_SCAN_STATUS, 32'h0708);
		lvl(24'h000204);
		rd(ADCSG_OFS_SCAN_STATUS, 32'h0608);
		lvl(24'h000004);
		rd(ADCSG_OFS_SCAN_STATUS, 32'h0408);
		lvl(24'h000000);
		rd(ADCSG_OFS_SCAN_STATUS, 32'h0008);
		rd(ADCSG_OFS_SCAN_CONTROL, 32'h3);
		clk_en <= 1'b0;
		fork
			rd(ADCSG_OFS_SCAN_STATUS, 32'h0008);
			begin
				repeat (2) @(posedge pclk);
				clk_en <= 1'b1;
			end
		join
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		rd(ADCSG_OFS_SCAN_STATUS, 32'h0);
		clk_en <= 1'b0;
		pulse(5'h08, 8'h01, 8'h00);
		clk_en <= 1'b1;
		rd(ADCSG_OFS_SCAN_STATUS, 32'h0);
		close_out();
	end
endmodule : adcsg_scan_status_tb
